// >>> lcdi_slave.sv
`timescale 1ns/10ps
// Summary of operation
// - one bit per clock pulse, data stable high
// - data falling with clock high is start
// - data rising with clock high is stop
// - lines released high while idle
// - master opens with start then address
// - eight data bits then one acknowledge
// - addressed receiver acknowledges every byte
// - ack low through acknowledge clock high
// - receive only; only output is ack
// - selection by address, commands and strap
// - two addresses, fixed upper six bits
// - address bit 1 must match select strap
// - write only; reads are not answered
// - matching devices acknowledge address together
// - mismatch ignores transfer until stop or repeated start
// - ack driven on separate ack pin
// - unconnected ack means master ignores it
// - unique three-bit subaddress per device
// - device-select loads three-bit subaddress counter
module lcdi_slave (
   input  wire logic  core_clk_i,
   input  wire logic  reset_i,
   lcdi_link_if.device link,
   input  wire logic  addr_select_strap_i,
   input  wire logic  subaddr_strap_bit0_i,
   input  wire logic  subaddr_strap_bit1_i,
   input  wire logic  subaddr_strap_bit2_i,
   output logic [7:0] rx_byte_o,
   output logic       rx_valid_o,
   output logic       rx_first_o,
   output logic       dev_selected_o,
   output logic       busy_o
);
   import lcdi_pkg::*;

   // ----------------------------------------
   // state record
   // ----------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA, ST_IGNORE} lcdi_sl_state_t;

   typedef struct packed {
      logic [1:0]     scl_sync;
      logic [1:0]     sda_sync;
      logic [1:0]     sel_sync;
      logic [2:0]     sub_meta;
      logic [2:0]     sub_sync;
      logic           scl_d;
      logic           sda_d;
      lcdi_sl_state_t state;
      logic [3:0]     bit_cnt;
      logic [7:0]     shift;
      logic           ack_pend;
      logic           ack_drv_n;
      logic [2:0]     sub_cnt;
      logic [7:0]     rx_byte;
      logic           rx_valid;
      logic           rx_first;
      logic           first_data;
      logic           selected;
      logic           busy;
   } lcdi_sl_regs_t;

   lcdi_sl_regs_t s_reg;
   lcdi_sl_regs_t s_next;

   logic [2:0] sub_strap;
   logic       sel_strap;
   logic       scl;
   logic       sda;
   logic       scl_rise;
   logic       scl_fall;
   logic       start_det;
   logic       stop_det;
   logic [7:0] full_byte;

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic addr_match(input logic [7:0] b, input logic sel);
      addr_match = (b[ADDR_FIXED_MSB:ADDR_FIXED_LSB] == ADDR_FIXED)
                 && (b[ADDR_SEL_POS] == sel)
                 && (b[ADDR_RW_POS] == ADDR_RW_WRITE);
   endfunction

   // ----------------------------------------
   // line sampling
   // ----------------------------------------
   // edge detect lags the wires by two cycles; ample at these link rates
   assign sub_strap = s_reg.sub_sync;
   assign sel_strap = s_reg.sel_sync[1];
   assign scl       = s_reg.scl_sync[1];
   assign sda       = s_reg.sda_sync[1];
   assign scl_rise  = scl & ~s_reg.scl_d;
   assign scl_fall  = ~scl & s_reg.scl_d;
   // changes of data while clock stays high are control conditions
   assign start_det = scl & s_reg.scl_d & s_reg.sda_d & ~sda;
   assign stop_det  = scl & s_reg.scl_d & ~s_reg.sda_d & sda;
   assign full_byte = {s_reg.shift[6:0], sda};

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      s_next          = s_reg;
      s_next.scl_sync = {s_reg.scl_sync[0], link.scl_line};
      s_next.sda_sync = {s_reg.sda_sync[0], link.sda_line};
      // straps are pins too, so they pass the same two flops
      s_next.sel_sync = {s_reg.sel_sync[0], addr_select_strap_i};
      s_next.sub_meta = {subaddr_strap_bit2_i, subaddr_strap_bit1_i, subaddr_strap_bit0_i};
      s_next.sub_sync = s_reg.sub_meta;
      s_next.scl_d    = scl;
      s_next.sda_d    = sda;
      s_next.rx_valid = 1'b0;
      if (start_det) begin
         // repeated start also restarts address phase
         s_next.state     = ST_ADDR;
         s_next.bit_cnt   = BIT_CNT_RESET;
         s_next.ack_pend  = 1'b0;
         s_next.ack_drv_n = 1'b1;
         s_next.busy      = 1'b1;
      end else if (stop_det) begin
         s_next.state     = ST_IDLE;
         s_next.ack_pend  = 1'b0;
         s_next.ack_drv_n = 1'b1;
         s_next.busy      = 1'b0;
         s_next.selected  = 1'b0;
      end else begin
         case (s_reg.state)
            ST_IDLE: begin
               s_next.ack_drv_n = 1'b1;
            end
            ST_ADDR, ST_DATA: begin
               if (scl_rise && s_reg.bit_cnt < BIT_CNT_ACK) begin
                  s_next.shift   = full_byte;
                  s_next.bit_cnt = s_reg.bit_cnt + 4'h1;
                  if (s_reg.bit_cnt == BIT_CNT_ACK - 4'h1) begin
                     if (s_reg.state == ST_ADDR) begin
                        if (addr_match(full_byte, sel_strap)) begin
                           s_next.ack_pend   = 1'b1;
                           s_next.first_data = 1'b1;
                        end else begin
                           s_next.state = ST_IGNORE;
                        end
                     end else begin
                        s_next.ack_pend = 1'b1;
                        s_next.rx_byte  = full_byte;
                        s_next.rx_valid = 1'b1;
                        s_next.rx_first = s_reg.first_data;
                        s_next.first_data = 1'b0;
                        if (full_byte[7:DEVSEL_OP_LSB] == DEVSEL_OPCODE) begin
                           s_next.sub_cnt = full_byte[2:0];
                        end
                     end
                  end
               end
               // drive ack from the falling edge after bit 8 to the falling edge after the ack pulse
               if (scl_fall && s_reg.ack_pend) begin
                  s_next.ack_drv_n = 1'b0;
                  s_next.ack_pend  = 1'b0;
               end else if (scl_fall && s_reg.bit_cnt == BIT_CNT_ACK) begin
                  s_next.ack_drv_n = 1'b1;
                  s_next.bit_cnt   = BIT_CNT_RESET;
                  s_next.state     = ST_DATA;
               end
               s_next.selected = (s_reg.state == ST_DATA)
                               && (s_reg.sub_cnt == sub_strap);
            end
            ST_IGNORE: begin
               s_next.ack_drv_n = 1'b1;
               s_next.selected  = 1'b0;
            end
            default: begin
               s_next.state = ST_IDLE;
            end
         endcase
      end
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         s_reg           <= '0;
         s_reg.scl_sync  <= 2'h3;
         s_reg.sda_sync  <= 2'h3;
         s_reg.scl_d     <= 1'b1;
         s_reg.sda_d     <= 1'b1;
         s_reg.state     <= ST_IDLE;
         s_reg.ack_drv_n <= 1'b1;
         s_reg.sub_cnt   <= SUBADDR_RESET;
      end else begin
         s_reg <= s_next;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   // only the ack pin is ever driven by this end
   assign link.ack_oe_n   = s_reg.ack_drv_n;
   assign rx_byte_o       = s_reg.rx_byte;
   assign rx_valid_o      = s_reg.rx_valid;
   assign rx_first_o      = s_reg.rx_first;
   assign dev_selected_o  = s_reg.selected;
   assign busy_o          = s_reg.busy;
endmodule

// >>> lcdi_pkg.sv
package lcdi_pkg;
   // ----------------------------------------
   // slave address fields
   // ----------------------------------------
   localparam logic [5:0] ADDR_FIXED      = 6'h1c;
   localparam int         ADDR_FIXED_MSB  = 7;
   localparam int         ADDR_FIXED_LSB  = 2;
   localparam int         ADDR_SEL_POS    = 1;
   localparam int         ADDR_RW_POS     = 0;
   localparam logic       ADDR_RW_WRITE   = 1'b0;
   // ----------------------------------------
   // device-select command
   // ----------------------------------------
   localparam logic [4:0] DEVSEL_OPCODE   = 5'h1c;
   localparam int         DEVSEL_OP_LSB   = 3;
   localparam logic [2:0] SUBADDR_RESET   = 3'h0;
   // ----------------------------------------
   // framing and timing
   // ----------------------------------------
   localparam int         BYTE_BITS       = 8;
   localparam logic [3:0] BIT_CNT_RESET   = 4'h0;
   localparam logic [3:0] BIT_CNT_ACK     = 4'h8;
   localparam int         CORE_CLK_MHZ    = 200;
   localparam int         LINK_PERIOD_NS  = 2500;
   localparam int         LINK_HALF_CYC   = (LINK_PERIOD_NS * CORE_CLK_MHZ) / 2000;
   localparam logic [15:0] HALF_CYC_RESET = 16'h0000;
endpackage

// >>> lcdi_link_if.sv
`timescale 1ns/10ps
interface lcdi_link_if;
   // ----------------------------------------
   // two-wire link, open drain, oe low = drive low
   // ----------------------------------------
   logic scl_oe_n;
   logic sda_oe_n;
   logic ack_oe_n;
   logic ack_joined;
   wire  scl_line = scl_oe_n;
   wire  sda_line = sda_oe_n & (ack_joined ? ack_oe_n : 1'b1);

   modport device (
      input  scl_line,
      input  sda_line,
      output ack_oe_n
   );
   modport master (
      input  scl_line,
      input  sda_line,
      output scl_oe_n,
      output sda_oe_n
   );
endinterface

// >>> lcdi_master.sv
`timescale 1ns/10ps
module lcdi_master #(
   parameter int HALF_CYC = lcdi_pkg::LINK_HALF_CYC
) (
   input  wire logic  core_clk_i,
   input  wire logic  reset_i,
   lcdi_link_if.master link,
   input  wire logic  cmd_start_i,
   input  wire logic  cmd_stop_i,
   input  wire logic  cmd_write_i,
   input  wire logic  ignore_ack_i,
   input  wire logic [7:0] wr_byte_i,
   output logic       ready_o,
   output logic       nack_o,
   output logic       done_o
);
   import lcdi_pkg::*;

   typedef enum logic [2:0] {MS_IDLE, MS_START, MS_BIT, MS_ACK, MS_STOP, MS_HOLD} lcdi_ms_state_t;

   typedef struct packed {
      lcdi_ms_state_t state;
      logic [15:0]    tick_cnt;
      logic [1:0]     phase;
      logic [3:0]     bit_cnt;
      logic [7:0]     shift;
      logic           scl_n;
      logic           sda_n;
      logic [1:0]     sda_sync;
      logic           ignore;
      logic           nack;
      logic           done;
      logic           ready;
   } lcdi_ms_regs_t;

   lcdi_ms_regs_t m_reg;
   lcdi_ms_regs_t m_next;
   logic          tick;

   assign tick = (m_reg.tick_cnt == 16'(HALF_CYC - 1));

   // ----------------------------------------
   // next state: four quarter steps per bit
   // ----------------------------------------
   always_comb begin
      m_next          = m_reg;
      m_next.sda_sync = {m_reg.sda_sync[0], link.sda_line};
      m_next.done     = 1'b0;
      m_next.tick_cnt = tick ? HALF_CYC_RESET : m_reg.tick_cnt + 16'h0001;
      case (m_reg.state)
         MS_IDLE: begin
            m_next.tick_cnt = HALF_CYC_RESET;
            m_next.ready    = 1'b1;
            if (cmd_start_i) begin
               // new transfer only from idle bus
               m_next.state  = MS_START;
               m_next.shift  = wr_byte_i;
               m_next.ignore = ignore_ack_i;
               m_next.ready  = 1'b0;
               m_next.phase  = 2'h0;
            end
         end
         MS_START: if (tick) begin
            m_next.sda_n   = 1'b0;
            m_next.state   = MS_BIT;
            m_next.bit_cnt = BIT_CNT_RESET;
            m_next.phase   = 2'h0;
         end
         MS_BIT, MS_ACK: if (tick) begin
            m_next.phase = m_reg.phase + 2'h1;
            case (m_reg.phase)
               2'h0: begin
                  m_next.scl_n = 1'b0;
               end
               2'h1: begin
                  // data set while clock low only
                  m_next.sda_n = (m_reg.state == MS_BIT) ? m_reg.shift[7] : 1'b1;
               end
               2'h2: begin
                  m_next.scl_n = 1'b1;
               end
               default: begin
                  if (m_reg.state == MS_ACK) begin
                     m_next.nack  = m_reg.sda_sync[1] & ~m_reg.ignore;
                     m_next.state = MS_HOLD;
                     m_next.ready = 1'b1;
                     m_next.done  = 1'b1;
                  end else begin
                     m_next.shift   = {m_reg.shift[6:0], 1'b0};
                     m_next.bit_cnt = m_reg.bit_cnt + 4'h1;
                     if (m_reg.bit_cnt == BIT_CNT_ACK - 4'h1) begin
                        m_next.state = MS_ACK;
                     end
                  end
               end
            endcase
         end
         MS_HOLD: begin
            m_next.tick_cnt = HALF_CYC_RESET;
            m_next.phase    = 2'h0;
            if (cmd_write_i) begin
               m_next.shift   = wr_byte_i;
               m_next.bit_cnt = BIT_CNT_RESET;
               m_next.state   = MS_BIT;
               m_next.ready   = 1'b0;
            end else if (cmd_stop_i) begin
               m_next.state = MS_STOP;
               m_next.ready = 1'b0;
            end
         end
         MS_STOP: if (tick) begin
            m_next.phase = m_reg.phase + 2'h1;
            case (m_reg.phase)
               2'h0: m_next.scl_n = 1'b0;
               2'h1: m_next.sda_n = 1'b0;
               2'h2: m_next.scl_n = 1'b1;
               default: begin
                  m_next.sda_n = 1'b1;
                  m_next.state = MS_IDLE;
                  m_next.done  = 1'b1;
               end
            endcase
         end
         default: begin
            m_next.state = MS_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         m_reg          <= '0;
         m_reg.state    <= MS_IDLE;
         m_reg.scl_n    <= 1'b1;
         m_reg.sda_n    <= 1'b1;
         m_reg.sda_sync <= 2'h3;
      end else begin
         m_reg <= m_next;
      end
   end

   assign link.scl_oe_n = m_reg.scl_n;
   assign link.sda_oe_n = m_reg.sda_n;
   assign ready_o       = m_reg.ready;
   assign nack_o        = m_reg.nack;
   assign done_o        = m_reg.done;
endmodule

// >>> lcdi_link_assertions.sv
`timescale 1ns/10ps
module lcdi_link_assertions
   import lcdi_pkg::*;
#(
   parameter int HALF_CYC = 25
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   input wire logic scl_line,
   input wire logic sda_line,
   input wire logic sda_oe_n,
   input wire logic ack_oe_n,
   input wire logic ack_joined,
   input wire logic addr_select_strap_i
);
   // ----------------------------------------
   // frame tracking seen from the wires
   // ----------------------------------------
   localparam int ACK_MAX = 5 * HALF_CYC;
   logic       scl_q, sda_q, in_frame, first, addr_ok, start_seen, stop_seen, match;
   logic [3:0] cnt;
   logic [7:0] sr;
   assign start_seen = scl_q && scl_line && sda_q && !sda_line;
   assign stop_seen  = scl_q && scl_line && !sda_q && sda_line;
   assign match      = sr[7:2] == ADDR_FIXED && sr[1] == addr_select_strap_i && sr[0] == ADDR_RW_WRITE;
   always_ff @(posedge core_clk_i) begin
      scl_q <= scl_line;
      sda_q <= sda_line;
      if (reset_i || start_seen || stop_seen) begin
         cnt      <= BIT_CNT_RESET;
         first    <= 1'b1;
         in_frame <= start_seen && !reset_i;
         addr_ok  <= 1'b0;
      end else if (scl_line && !scl_q) begin
         sr  <= {sr[6:0], sda_line};
         cnt <= (cnt == BIT_CNT_ACK) ? BIT_CNT_RESET : cnt + 4'h1;
         if (cnt == BIT_CNT_ACK) begin
            first <= 1'b0;
            if (first) begin
               addr_ok <= match;
            end
         end
      end
   end
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   property p_ack_slot; $fell(ack_oe_n) |-> !scl_line && in_frame && cnt == BIT_CNT_ACK; endproperty
   a_ack_slot: assert property (p_ack_slot) else $error("ack pulled outside the ninth clock slot");
   property p_ack_rise_low; $rose(ack_oe_n) |-> !scl_line; endproperty
   a_ack_rise_low: assert property (p_ack_rise_low) else $error("ack released with clock high");
   property p_ack_hold; scl_line && !ack_oe_n |=> !ack_oe_n || !scl_line; endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack not held through clock high");
   property p_ack_bounded; $fell(ack_oe_n) |-> ##[1:ACK_MAX] ack_oe_n; endproperty
   a_ack_bounded: assert property (p_ack_bounded) else $error("ack held too long");
   property p_ack_due; $rose(scl_line) && in_frame && cnt == BIT_CNT_ACK && (first ? match : addr_ok) |-> !ack_oe_n;
   endproperty
   a_ack_due: assert property (p_ack_due) else $error("selected device missed its ack");
   property p_no_foreign; !ack_oe_n |-> in_frame && (first ? match : addr_ok); endproperty
   a_no_foreign: assert property (p_no_foreign) else $error("ack during an ignored transfer");
   property p_addr_fields; $fell(ack_oe_n) && first |-> sr[7:2] == ADDR_FIXED && sr[0] == ADDR_RW_WRITE; endproperty
   a_addr_fields: assert property (p_addr_fields) else $error("ack on foreign or read address");
   property p_strap; $fell(ack_oe_n) && first |-> sr[1] == addr_select_strap_i; endproperty
   a_strap: assert property (p_strap) else $error("ack with select strap mismatch");
   property p_wire; !ack_oe_n && ack_joined |-> !sda_line; endproperty
   a_wire: assert property (p_wire) else $error("joined ack not seen on data line");
   property p_sda_stable; scl_line && $past(scl_line) && $changed(sda_oe_n)
      |-> (cnt == BIT_CNT_RESET && !sda_oe_n) || (cnt == 4'h1 && sda_oe_n); endproperty
   a_sda_stable: assert property (p_sda_stable) else $error("data moved with clock high");
   property p_idle; !in_frame && !start_seen |-> scl_line && sda_line; endproperty
   a_idle: assert property (p_idle) else $error("lines not released while idle");
endmodule

// >>> lcd_driver_i2c_slave_front_end_bench.sv
`timescale 1ns/10ps
module lcd_driver_i2c_slave_front_end_bench;
   import lcdi_pkg::*;
   // ----------------------------------------
   // harness
   // ----------------------------------------
   localparam int         HC = 25;
   localparam logic [7:0] CORNER [5] = '{8'h70, 8'h72, 8'h72, 8'h71, 8'hf0};
   logic       core_clk_i = 1'b0, reset_i = 1'b1, c_start, c_stop, c_write, ign, strap;
   logic       ready, nack, done, rx_valid, rx_first, dev_sel, busy;
   logic [2:0] sub;
   logic [7:0] wr_byte, rx_byte;
   logic [31:0] seed = 32'hfe0b;
   logic [8:0] rxq [$];
   int         n_mismatch = 0, num_checks = 0, cycles = 0;
   lcdi_link_if link();
   lcdi_slave i_lcdi_slave (.core_clk_i(core_clk_i), .reset_i(reset_i), .link(link.device),
      .addr_select_strap_i(strap), .subaddr_strap_bit0_i(sub[0]), .subaddr_strap_bit1_i(sub[1]),
      .subaddr_strap_bit2_i(sub[2]), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid), .rx_first_o(rx_first),
      .dev_selected_o(dev_sel), .busy_o(busy));
   lcdi_master #(.HALF_CYC(HC)) i_lcdi_master (.core_clk_i(core_clk_i), .reset_i(reset_i), .link(link.master),
      .cmd_start_i(c_start), .cmd_stop_i(c_stop), .cmd_write_i(c_write), .ignore_ack_i(ign),
      .wr_byte_i(wr_byte), .ready_o(ready), .nack_o(nack), .done_o(done));
   lcdi_link_assertions #(.HALF_CYC(HC)) i_lcdi_link_assertions (.core_clk_i(core_clk_i), .reset_i(reset_i),
      .scl_line(link.scl_line), .sda_line(link.sda_line), .sda_oe_n(link.sda_oe_n), .ack_oe_n(link.ack_oe_n),
      .ack_joined(link.ack_joined), .addr_select_strap_i(strap));
   always #2.5 core_clk_i = ~core_clk_i;
   always @(posedge core_clk_i) begin
      cycles++;
      if (rx_valid === 1'b1) begin
         rxq.push_back({rx_first, rx_byte});
      end
      if (cycles == 90000) begin
         n_mismatch++;
         conclude();
      end
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic addr_ok(input logic [7:0] a, input logic s);
      return a[7:2] == ADDR_FIXED && a[1] == s && a[0] == ADDR_RW_WRITE;
   endfunction
   task automatic chk_bit(input string what, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %b seen %b", what, e, g);
      end
   endtask
   task automatic chk_word(input string what, input logic [8:0] e, input logic [8:0] g);
      num_checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   // kind 0 start with address, 1 write, 2 stop; waits for the byte or stop to finish
   task automatic issue(input int kind, input logic [7:0] b);
      int n;
      n = 0;
      while (ready !== 1'b1 && n < 4000) begin
         @(posedge core_clk_i);
         #1 n++;
      end
      wr_byte = b;
      c_start = kind == 0;
      c_write = kind == 1;
      c_stop  = kind == 2;
      @(posedge core_clk_i);
      #1 c_start = 1'b0;
      c_write = 1'b0;
      c_stop  = 1'b0;
      n = 0;
      while (done !== 1'b1 && n < 4000) begin
         @(posedge core_clk_i);
         #1 n++;
      end
      chk_bit("done", 1'b1, done);
      chk_bit("ready", kind != 2, ready);
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   initial begin
      logic [31:0] r;
      logic [7:0]  a, d;
      logic        ok;
      int          nb;
      {c_start, c_stop, c_write, ign, strap, sub, wr_byte} = '0;
      link.ack_joined = 1'b1;
      repeat (12) @(posedge core_clk_i);
      #1 reset_i = 1'b0;
      for (int t = 0; t < 12; t++) begin
         r = rnd();
         strap = (t < 5) ? (t == 1) : r[0];
         sub = r[3:1];
         ign = (t < 5) ? 1'b0 : r[4];
         link.ack_joined = (t < 5) ? 1'b1 : r[5];
         a = (t < 5) ? CORNER[t] : (r[6] ? {ADDR_FIXED, r[8:7]} : r[16:9]);
         ok = addr_ok(a, strap);
         rxq.delete();
         issue(0, a);
         chk_bit("addr_nack", ign ? 1'b0 : !(ok && link.ack_joined), nack);
         chk_bit("busy", 1'b1, busy);
         nb = 1 + r[18:17];
         for (int i = 0; i < nb; i++) begin
            r = rnd();
            d = r[0] ? {DEVSEL_OPCODE, r[1] ? sub : r[4:2]} : r[12:5];
            issue(1, d);
            chk_bit("data_nack", ign ? 1'b0 : !(ok && link.ack_joined), nack);
            chk_bit("rx_count", ok, rxq.size() == 1);
            if (ok && rxq.size() > 0) begin
               chk_word("rx_byte", {i == 0, d}, rxq.pop_front());
            end
            rxq.delete();
            if (d[7:3] == DEVSEL_OPCODE) begin
               chk_bit("dev_selected", ok && d[2:0] == sub, dev_sel);
            end
         end
         issue(2, 8'h00);
         repeat (10) @(posedge core_clk_i);
         #1 chk_bit("busy_after_stop", 1'b0, busy);
         chk_bit("ack_released", 1'b1, link.ack_oe_n);
      end
      conclude();
   end
endmodule
